// ### phdma_pkg.sv
package phdma_pkg;
    localparam int PHDMA_DATA_W = 8;
    localparam int PHDMA_FIFO_DEPTH = 32;
    localparam logic [2:0] PHDMA_MODE_OUT2 = 3'h6;
    localparam logic [2:0] PHDMA_MODE_OUT1 = 3'h2;
    localparam logic [2:0] PHDMA_MODE_IN2 = 3'h5;
    localparam logic [2:0] PHDMA_MODE_IN1 = 3'h1;
    localparam logic [1:0] PHDMA_MODE_BIDIR_LOW = 2'h0;
    localparam logic [1:0] PHDMA_MODE_OFF_LOW = 2'h3;
    localparam logic PHDMA_CH_CAPTURE = 1'b0;
    localparam logic PHDMA_DIR_IN = 1'b1;
    localparam logic [7:0] PHDMA_DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        PHDMA_OFF, PHDMA_IN2, PHDMA_IN1, PHDMA_OUT2, PHDMA_OUT1, PHDMA_BIDIR
    } phdma_mode_e;

    typedef struct packed {
        logic [2:0] mode_bits;
        logic dma_enable_active_low;
        logic dma_direction;
        logic dma_channel_select;
    } phdma_cfg_s;

    typedef struct packed {
        logic dma_request;
        logic input_ready;
        logic output_ready;
        logic port_oe;
    } phdma_stat_s;
endpackage

// ### phdma_fifo.sv
`timescale 1ns/100ps
module phdma_fifo
    import phdma_pkg::*;
#(
    parameter int WIDTH = PHDMA_DATA_W,
    parameter int DEPTH = PHDMA_FIFO_DEPTH
)(
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [WIDTH-1:0] out_q;
    logic out_v_q;
    wire push = in_valid && in_ready;
    wire pop_out = out_valid && out_ready;
    wire mem_nonempty = cnt_q != '0;
    // Output register refills when empty or being drained
    wire load = mem_nonempty && (!out_v_q || pop_out);
    // The output register counts as a slot, so the buffer never holds more than DEPTH words
    assign in_ready = (cnt_q + (AW+1)'(out_v_q)) != (AW+1)'(DEPTH);
    assign out_valid = out_v_q;
    assign out_data = out_q;

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            out_v_q <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (load)
            begin
                rd_q <= rd_q + 1'b1;
                out_q <= mem[rd_q];
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
            if (load)
            begin
                out_v_q <= 1'b1;
            end
            else if (pop_out)
            begin
                out_v_q <= 1'b0;
            end
        end
    end
endmodule // phdma_fifo

// ### phdma_port.sv
`timescale 1ns/100ps
module phdma_port
    import phdma_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire phdma_cfg_s cfg,
    input wire logic input_strobe,
    input wire logic output_strobe,
    input wire logic timer_capture_input,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic input_ready,
    output logic output_ready,
    output logic capture_dma_channel,
    input wire logic dma_read,
    output logic [7:0] dma_rdata,
    input wire logic dma_write,
    input wire logic [7:0] dma_wdata,
    output logic dma_wready,
    output logic stream_valid,
    input wire logic stream_ready,
    output logic [7:0] stream_data
);
    // Mode decode
    wire dma_on = !cfg.dma_enable_active_low && cfg.dma_channel_select == PHDMA_CH_CAPTURE;
    wire m_in2 = cfg.mode_bits == PHDMA_MODE_IN2;
    wire m_in1 = cfg.mode_bits == PHDMA_MODE_IN1;
    wire m_out2 = cfg.mode_bits == PHDMA_MODE_OUT2;
    wire m_out1 = cfg.mode_bits == PHDMA_MODE_OUT1;
    wire m_bidir = cfg.mode_bits[1:0] == PHDMA_MODE_BIDIR_LOW;
    wire bd_in = m_bidir && cfg.dma_direction == PHDMA_DIR_IN;
    wire bd_out = m_bidir && cfg.dma_direction != PHDMA_DIR_IN;
    phdma_mode_e mode_d;
    phdma_mode_e mode_q;
    assign mode_d = m_in2 ? PHDMA_IN2 : m_in1 ? PHDMA_IN1 : m_out2 ? PHDMA_OUT2 :
        m_out1 ? PHDMA_OUT1 : m_bidir ? PHDMA_BIDIR : PHDMA_OFF;
    wire mode_entry = mode_d != mode_q;

    // Strobe synchronisers; the first stage feeds only the second
    logic [1:0] isync_q;
    logic [1:0] osync_q;
    logic [1:0] tsync_q;
    logic is_q;
    logic os_q;
    logic ts_q;
    wire is_rise = isync_q[1] && !is_q;
    wire os_rise = osync_q[1] && !os_q;
    wire os_fall = !osync_q[1] && os_q;
    wire ts_edge = tsync_q[1] != ts_q;

    logic ir_q;
    logic or_q;
    logic oe_q;
    logic req_q;
    logic [7:0] in_latch_q;
    logic [7:0] out_slave_q;
    logic [7:0] pin_q;
    logic [7:0] pin_d1_q;
    logic [7:0] pin_d2_q;
    logic wr_busy_q;

    // Input latch loads only while input_ready is high, and in the handshake modes only while the strobe is also low
    wire in_hs = (mode_q == PHDMA_IN2) || (mode_q == PHDMA_BIDIR && bd_in);
    wire in_load = in_hs ? (ir_q && !isync_q[1]) : (mode_q == PHDMA_IN1 && ir_q);
    wire out_hs = (mode_q == PHDMA_OUT2) || (mode_q == PHDMA_BIDIR && bd_out);
    wire in_rise_evt = in_hs && ir_q && is_rise;
    wire out_rise_evt = out_hs && os_rise;
    wire t_evt = ts_edge && (mode_q == PHDMA_OUT1 || mode_q == PHDMA_IN1);
    wire fifo_in_ready;
    wire slave_write = dma_write && fifo_in_ready;

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            mode_q <= PHDMA_OFF;
            // Idle-high start, so leaving reset shows no false rising edge
            isync_q <= '1;
            osync_q <= '1;
            tsync_q <= '1;
            is_q <= 1'b1;
            os_q <= 1'b1;
            ts_q <= 1'b1;
        end
        else
        begin
            mode_q <= mode_d;
            isync_q <= {isync_q[0], input_strobe};
            osync_q <= {osync_q[0], output_strobe};
            tsync_q <= {tsync_q[0], timer_capture_input};
            is_q <= isync_q[1];
            os_q <= osync_q[1];
            ts_q <= tsync_q[1];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn || !dma_on || mode_d == PHDMA_OFF)
        begin
            ir_q <= 1'b0;
            or_q <= 1'b0;
            oe_q <= 1'b0;
            req_q <= 1'b0;
            wr_busy_q <= 1'b0;
        end
        else if (mode_entry)
        begin
            ir_q <= 1'b1;
            or_q <= 1'b0;
            oe_q <= 1'b0;
            req_q <= 1'b0;
            wr_busy_q <= 1'b0;
        end
        else
        begin
            req_q <= in_rise_evt || out_rise_evt || t_evt;
            // Port read reopens loading; a read is one cycle so 1-line ready returns next edge
            if (in_rise_evt || (mode_q == PHDMA_IN1 && dma_read))
            begin
                ir_q <= 1'b0;
            end
            else if (dma_read)
            begin
                ir_q <= 1'b1;
            end
            else if (mode_q == PHDMA_IN1)
            begin
                ir_q <= 1'b1;
            end
            wr_busy_q <= slave_write;
            if (mode_q == PHDMA_OUT1 && slave_write)
            begin
                or_q <= 1'b0;
            end
            else if (out_rise_evt)
            begin
                or_q <= 1'b0;
            end
            else if (slave_write || (mode_q == PHDMA_OUT1 && wr_busy_q))
            begin
                or_q <= 1'b1;
            end
            if (mode_q == PHDMA_BIDIR && bd_out && os_fall)
            begin
                oe_q <= 1'b1;
            end
            else if (os_rise || mode_q != PHDMA_BIDIR || !bd_out)
            begin
                oe_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            in_latch_q <= PHDMA_DATA_RST;
            out_slave_q <= PHDMA_DATA_RST;
            pin_q <= PHDMA_DATA_RST;
            pin_d1_q <= PHDMA_DATA_RST;
            pin_d2_q <= PHDMA_DATA_RST;
        end
        else
        begin
            // Pins delayed to line up with the synchronised strobe
            pin_d1_q <= pin_in;
            pin_d2_q <= pin_d1_q;
            if (in_load)
            begin
                in_latch_q <= pin_d2_q;
            end
            if (slave_write)
            begin
                out_slave_q <= dma_wdata;
            end
            // Pins update at strobe fall in bidir: previous transfer's data shown
            if (mode_q != PHDMA_BIDIR || os_fall)
            begin
                pin_q <= out_slave_q;
            end
        end
    end

    // Read data is a latch copy so input_ready low keeps it stable
    assign dma_rdata = in_latch_q;
    assign pin_out = pin_q;
    assign pin_oe = (mode_q == PHDMA_BIDIR) ? {8{oe_q}} :
        ((mode_q == PHDMA_OUT2 || mode_q == PHDMA_OUT1) ? 8'hff : 8'h00);
    assign input_ready = ir_q;
    assign output_ready = or_q;
    assign capture_dma_channel = req_q;
    assign dma_wready = fifo_in_ready;

    // Each port read also streams the latched input out through a buffer, except a read made while the buffer is full
    phdma_fifo #(.WIDTH(PHDMA_DATA_W), .DEPTH(PHDMA_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(dma_read),
        .in_ready(fifo_in_ready),
        .in_data(in_latch_q),
        .out_valid(stream_valid),
        .out_ready(stream_ready),
        .out_data(stream_data)
    );

    phdma_stat_s st;
    assign st = '{req_q, ir_q, or_q, oe_q};

    strobe_req_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == mode_d && in_rise_evt) |=> st.dma_request && !st.input_ready)
        else $error("Input strobe edge did not request");
    read_ready_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == PHDMA_IN2 && mode_d == PHDMA_IN2 && dma_read && !in_rise_evt)
        |=> input_ready)
        else $error("Port read did not set input ready");
    out_rise_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == PHDMA_OUT2 && mode_d == PHDMA_OUT2 && out_rise_evt
        && !slave_write) |=> !output_ready && capture_dma_channel)
        else $error("Output strobe edge mishandled");
    write_ready_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == PHDMA_OUT2 && mode_d == PHDMA_OUT2 && slave_write
        && !out_rise_evt) |=> output_ready)
        else $error("Slave write did not set output ready");
    one_out_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == PHDMA_OUT1 && mode_d == PHDMA_OUT1 && slave_write)
        |=> !output_ready)
        else $error("Output ready not low during write");
    entry_bidir_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_d == PHDMA_BIDIR && mode_q != PHDMA_BIDIR && mode_q != PHDMA_OFF)
        |=> input_ready && !output_ready && pin_oe == 8'h00)
        else $error("Bidirectional entry state wrong");
    reset_quiet_a: assert property (@(posedge clock) $past(!rstn)
        |-> !input_ready && !output_ready && !capture_dma_channel)
        else $error("Outputs active after reset");
    one_in_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == PHDMA_IN1 && mode_d == PHDMA_IN1 && dma_read)
        |=> !input_ready ##1 input_ready)
        else $error("One-line input ready sequence wrong");
    tristate_a: assert property (@(posedge clock) disable iff (!rstn)
        (dma_on && mode_q == PHDMA_BIDIR && mode_d == PHDMA_BIDIR && os_rise)
        |=> pin_oe == 8'h00)
        else $error("Drivers not tristated on strobe rise");

    cov_in2_c: cover property (@(posedge clock) mode_q == PHDMA_IN2 && in_rise_evt);
    cov_out2_c: cover property (@(posedge clock) mode_q == PHDMA_OUT2 && out_rise_evt);
    cov_bidir_c: cover property (@(posedge clock) mode_q == PHDMA_BIDIR && oe_q);
    cov_full_c: cover property (@(posedge clock) !fifo_in_ready);
endmodule // phdma_port

// ### phdma_periph.sv
`timescale 1ns/100ps
module phdma_periph (
    input wire logic clock,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic input_strobe,
    output logic output_strobe,
    output logic [7:0] pin_in
);
    initial
    begin
        input_strobe = 1'b1;
        output_strobe = 1'b1;
        pin_in = 8'h00;
    end
    task automatic set_data(input logic [7:0] d);
        @(negedge clock);
        pin_in = d;
    endtask
    // Phase length p is the pace: 1 is prompt, larger is slow
    task automatic put_byte(input logic [7:0] d, input int p);
        @(negedge clock);
        pin_in = d;
        input_strobe = 1'b0;
        repeat (p) @(negedge clock);
        input_strobe = 1'b1;
        repeat (p) @(negedge clock);
        pin_in = ~d; // Hold time over, stale data must not look valid
    endtask
    // Undriven pins read back inverted so a missing enable shows
    task automatic take_byte(output logic [7:0] d, input int p);
        @(negedge clock);
        output_strobe = 1'b0;
        repeat (p) @(negedge clock);
        d = (pin_oe === 8'hff) ? pin_out : ~pin_out;
        output_strobe = 1'b1;
        repeat (p) @(negedge clock);
    endtask
endmodule // phdma_periph

// ### testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    import phdma_pkg::*;
    logic clock, rstn, timer_manual, wire_strobes, dma_read, dma_write, stream_ready;
    logic input_strobe, output_strobe, timer_capture_input, input_ready, output_ready;
    logic capture_dma_channel, dma_wready, stream_valid;
    logic [7:0] pin_in, pin_out, pin_oe, dma_rdata, dma_wdata, stream_data, got;
    phdma_cfg_s cfg;
    logic [7:0] expq[$];
    int fail_count = 0, tests_run = 0, req_count = 0, cycles = 0, r0;
    // Off-chip wiring of the strobes onto the timer input, idle high
    assign timer_capture_input = wire_strobes ? (input_strobe & output_strobe)
        : timer_manual;
    phdma_port dut (.clock(clock), .rstn(rstn), .cfg(cfg), .input_strobe(input_strobe),
        .output_strobe(output_strobe), .timer_capture_input(timer_capture_input),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .input_ready(input_ready),
        .output_ready(output_ready), .capture_dma_channel(capture_dma_channel),
        .dma_read(dma_read), .dma_rdata(dma_rdata), .dma_write(dma_write),
        .dma_wdata(dma_wdata), .dma_wready(dma_wready), .stream_valid(stream_valid),
        .stream_ready(stream_ready), .stream_data(stream_data));
    phdma_periph periph (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .input_strobe(input_strobe), .output_strobe(output_strobe), .pin_in(pin_in));
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Requests are counted here so a pulse inside a task is never missed
    always @(posedge clock)
    begin
        cycles++;
        if (capture_dma_channel === 1'b1)
            req_count++;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic set_mode(input logic [2:0] m, input logic dir);
        @(negedge clock);
        cfg = '{mode_bits: m, dma_enable_active_low: 1'b0, dma_direction: dir,
            dma_channel_select: PHDMA_CH_CAPTURE};
        tick(4);
    endtask
    // Every read is copied to the stream, a full buffer drops the copy
    task automatic dma_rd(input logic [7:0] e);
        @(negedge clock);
        dma_read = 1'b1;
        if (expq.size() < PHDMA_FIFO_DEPTH)
            expq.push_back(e);
        @(negedge clock);
        dma_read = 1'b0;
    endtask
    task automatic dma_wr(input logic [7:0] d);
        @(negedge clock);
        dma_wdata = d;
        dma_write = 1'b1;
        @(negedge clock);
        dma_write = 1'b0;
    endtask
    task automatic pulse_timer();
        tick(1);
        timer_manual = ~timer_manual;
        tick(6);
    endtask
    // Sink stalls every other cycle while draining
    task automatic drain();
        logic [7:0] ev;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge clock);
            stream_ready = 1'b0;
            if (stream_valid === 1'b1 && i % 2 == 1)
            begin
                ev = expq.pop_front();
                `CHK("stream data", ev, stream_data)
                stream_ready = 1'b1;
            end
        end
        @(negedge clock);
        stream_ready = 1'b0;
        `CHK("stream left", 0, expq.size())
        `CHK("stream empty", 1'b0, stream_valid)
    endtask
    initial
    begin
        cfg = '{mode_bits: 3'h7, dma_enable_active_low: 1'b1, dma_direction: 1'b0,
            dma_channel_select: 1'b0};
        rstn = 1'b0;
        {timer_manual, wire_strobes} = 2'b11;
        {dma_read, dma_write, stream_ready, dma_wdata} = '0;
        tick(4);
        rstn = 1'b1;
        tick(2);
        `CHK("in ready rst", 1'b0, input_ready)
        `CHK("out ready rst", 1'b0, output_ready)
        `CHK("oe rst", 8'h00, pin_oe)
        periph.put_byte(8'h99, 4);
        tick(4);
        `CHK("req idle", 0, req_count)
        set_mode(PHDMA_MODE_IN2, PHDMA_DIR_IN);
        `CHK("in2 ready", 1'b1, input_ready)
        periph.put_byte(8'ha5, 1);
        tick(4);
        `CHK("in2 req", 1, req_count)
        `CHK("in2 busy", 1'b0, input_ready)
        `CHK("in2 latch", 8'ha5, dma_rdata)
        periph.put_byte(8'h3c, 4);
        tick(4);
        `CHK("in2 held", 8'ha5, dma_rdata)
        `CHK("in2 no req", 1, req_count)
        dma_rd(8'ha5);
        tick(1);
        `CHK("in2 rearm", 1'b1, input_ready)
        wire_strobes = 1'b0;
        set_mode(PHDMA_MODE_IN1, PHDMA_DIR_IN);
        periph.set_data(8'h77);
        tick(4);
        `CHK("in1 sample", 8'h77, dma_rdata)
        pulse_timer();
        `CHK("in1 req", 2, req_count)
        @(negedge clock);
        dma_read = 1'b1;
        expq.push_back(8'h77);
        @(negedge clock);
        dma_read = 1'b0;
        `CHK("in1 read low", 1'b0, input_ready)
        @(negedge clock);
        `CHK("in1 read end", 1'b1, input_ready)
        drain();
        for (int i = 0; i < 33; i++)
        begin
            periph.set_data(8'(i));
            tick(3);
            dma_rd(8'(i));
        end
        `CHK("stream full", 1'b1, stream_valid)
        `CHK("stream full ready", 1'b0, dma_wready)
        drain();
        wire_strobes = 1'b1;
        set_mode(PHDMA_MODE_OUT2, 1'b0);
        `CHK("out2 enter", 1'b0, output_ready)
        dma_wr(8'h5a);
        tick(1);
        `CHK("out2 written", 1'b1, output_ready)
        r0 = req_count;
        periph.take_byte(got, 4);
        tick(4);
        `CHK("out2 data", 8'h5a, got)
        `CHK("out2 taken", 1'b0, output_ready)
        `CHK("out2 req", r0 + 1, req_count)
        dma_wr(8'hc3);
        tick(1);
        `CHK("out2 refill", 1'b1, output_ready)
        wire_strobes = 1'b0;
        set_mode(PHDMA_MODE_OUT1, 1'b0);
        `CHK("out1 enter", 1'b0, output_ready)
        r0 = req_count;
        pulse_timer();
        `CHK("out1 req", r0 + 1, req_count)
        dma_wr(8'h01);
        tick(2);
        @(negedge clock);
        dma_wdata = 8'he1;
        dma_write = 1'b1;
        @(negedge clock);
        dma_write = 1'b0;
        `CHK("out1 writing", 1'b0, output_ready)
        @(negedge clock);
        `CHK("out1 ready", 1'b1, output_ready)
        `CHK("out1 pins", 8'he1, pin_out)
        wire_strobes = 1'b1;
        set_mode(3'h4, 1'b0);
        `CHK("bi in ready", 1'b1, input_ready)
        `CHK("bi out ready", 1'b0, output_ready)
        `CHK("bi oe", 8'h00, pin_oe)
        dma_wr(8'h11);
        tick(1);
        `CHK("bi written", 1'b1, output_ready)
        r0 = req_count;
        periph.take_byte(got, 4);
        tick(4);
        `CHK("bi data", 8'h11, got)
        `CHK("bi tristate", 8'h00, pin_oe)
        `CHK("bi taken", 1'b0, output_ready)
        `CHK("bi req", r0 + 1, req_count)
        dma_wr(8'h22);
        tick(2);
        `CHK("bi pipe hold", 8'h11, pin_out)
        periph.take_byte(got, 4);
        `CHK("bi pipe next", 8'h22, got)
        set_mode(3'h0, PHDMA_DIR_IN);
        r0 = req_count;
        periph.put_byte(8'he7, 3);
        tick(4);
        `CHK("bi in busy", 1'b0, input_ready)
        `CHK("bi in req", r0 + 1, req_count)
        `CHK("bi in latch", 8'he7, dma_rdata)
        dma_rd(8'he7);
        tick(1);
        `CHK("bi in rearm", 1'b1, input_ready)
        drain();
        final_report();
    end
endmodule // testbench
